// *** pkg/mdfs_params.svh ***
// Purpose: constants for the motor driver fault supervisor controller
// Assumes: 10 MHz clock, 100 ns period
// Notes:   software register map is local to this controller
`ifndef MDFS_PARAMS_SVH
`define MDFS_PARAMS_SVH

// Clock period in nanoseconds
`define MDFS_CLK_NS         100
// Least wait after a latched shutdown before clearing, in milliseconds
`define MDFS_RECOVER_MS     1000
`define MDFS_RECOVER_CYC    ((`MDFS_RECOVER_MS * 1000000 + `MDFS_CLK_NS - 1) / `MDFS_CLK_NS)
// Least low-side on time in every PWM cycle, in nanoseconds
`define MDFS_MIN_LOW_NS     50
`define MDFS_MIN_LOW_CYC    ((`MDFS_MIN_LOW_NS + `MDFS_CLK_NS - 1) / `MDFS_CLK_NS)
// Width of the clear-low pulse, in cycles
`define MDFS_CLR_LOW_CYC    4
// Register offsets
`define MDFS_REG_CTRL       4'h0
`define MDFS_REG_STATUS     4'h1
`define MDFS_REG_DUTY_A     4'h2
`define MDFS_REG_DUTY_B     4'h3
`define MDFS_REG_DUTY_C     4'h4
`define MDFS_REG_PERIOD     4'h5
// Control field positions
`define MDFS_CTRL_RUN       0
`define MDFS_CTRL_CLEAR     1
`define MDFS_CTRL_DERATE    2
// Reset values
`define MDFS_PERIOD_RST     16'h03E8
`define MDFS_DUTY_RST       16'h0000

`endif

// *** pkg/mdfs_pkg.sv ***
// Purpose: types for the motor driver fault supervisor controller
// Assumes: nothing
// Notes:   one-hot state codes
`default_nettype none
package mdfs_pkg;
    // Supervisor states
    typedef enum logic [4:0] {
        MDFS_PWRUP   = 5'h01,
        MDFS_RUN     = 5'h02,
        MDFS_WAIT    = 5'h04,
        MDFS_CLR_LO  = 5'h08,
        MDFS_IDLE    = 5'h10
    } mdfs_state_t;
    // Decoded device status
    typedef enum logic [1:0] {
        MDFS_ST_BOTH  = 2'h0,
        MDFS_ST_SHUT  = 2'h1,
        MDFS_ST_WARN  = 2'h2,
        MDFS_ST_OK    = 2'h3
    } mdfs_status_t;
endpackage : mdfs_pkg
`default_nettype wire

// *** hw/mdfs_pwm_phase.sv ***
// Purpose: one PWM phase with a guaranteed low-side time each period
// Assumes: period and duty stable across a period boundary
// Notes:   duty is clamped so the low part is never shorter than the minimum
`include "mdfs_params.svh"
`default_nettype none
module mdfs_pwm_phase (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Settings
    input  wire logic        enable,
    input  wire logic [15:0] period,
    input  wire logic [15:0] duty,
    input  wire logic [15:0] count,
    // Pin drive
    output logic             pwm
);
    import mdfs_pkg::*;

    localparam logic [15:0] MIN_LOW = 16'(`MDFS_MIN_LOW_CYC);

    // Highest duty that still leaves the low side on long enough
    wire logic [15:0] max_duty = (period > MIN_LOW) ? period - MIN_LOW : 16'h0000;
    wire logic [15:0] eff_duty = (duty > max_duty) ? max_duty : duty;
    wire logic        next_pwm = enable && (count < eff_duty);

    // Registered pin drive, free of glitches
    always_ff @(posedge clk) begin
        if (rst) begin
            pwm <= 1'b0;
        end else begin
            pwm <= next_pwm;
        end
    end

    // Low part of every period is at least the minimum
    a_low_side_min: assert property (@(posedge clk) disable iff (rst)
        (count >= max_duty) |-> ##1 !pwm)
        else $error("pwm high inside the reserved low-side time");
endmodule : mdfs_pwm_phase
`default_nettype wire

// *** hw/mdfs_ctrl.sv ***
// Purpose: controller that drives and supervises a three-phase half-bridge driver
// Assumes: device status pins are already synchronous to clk
// Notes:   fault pins are open-drain, read as levels; no clock on the link
//
// The address-and-strobe port and the placing of the registers were decided locally.
`include "mdfs_params.svh"
`default_nettype none
module mdfs_ctrl #(
    parameter int unsigned RECOVER_CYC = `MDFS_RECOVER_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Software port
    input  wire logic [3:0]         addr,
    input  wire logic [15:0]        wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic [15:0]             rdata,
    // Device drive pins
    output logic [2:0]              pwm,
    output logic [2:0]              phase_clear_n,
    // Device status pins, open-drain lines read as levels
    input  wire logic               shutdown_n,
    input  wire logic               thermal_warn_n,
    // Status to the system
    output mdfs_pkg::mdfs_status_t  dev_status,
    output logic                    derate
);
    import mdfs_pkg::*;

    localparam logic [31:0] REC_MAX = 32'(RECOVER_CYC);
    localparam logic [2:0]  CLR_LEN = 3'(`MDFS_CLR_LOW_CYC);

    mdfs_state_t  state;          // Supervisor state
    mdfs_state_t  next_state;     // Its next value
    logic         run;            // Software run request
    logic         derate_en;      // Software allows derating on warning
    logic         clear_req;      // Pending manual clear
    logic [15:0]  duty [3];       // Per-phase duty in cycles
    logic [15:0]  period;         // PWM period in cycles
    logic [15:0]  count;          // Shared PWM counter
    logic [31:0]  wait_cnt;       // Time since shutdown
    logic [2:0]   clr_cnt;        // Length of clear-low pulse
    logic         shut_seen;      // Sticky shutdown event
    logic         warn_seen;      // Sticky warning event
    logic         ok_prev;        // Shutdown flag one cycle back
    logic         run_prev;       // Running one cycle back

    // Register decode
    wire logic wr_ctrl   = wr && (addr == `MDFS_REG_CTRL);
    wire logic wr_period = wr && (addr == `MDFS_REG_PERIOD);
    wire logic rd_status = rd && (addr == `MDFS_REG_STATUS);
    wire logic shut_now  = !shutdown_n;
    wire logic warn_now  = !thermal_warn_n;
    wire logic wait_done = (wait_cnt >= REC_MAX - 32'd1);
    wire logic clr_done  = (clr_cnt == CLR_LEN - 3'd1);
    wire logic drive_on  = (state == MDFS_RUN);
    wire logic per_end   = (count >= period - 16'd1);

    // Flag pair decode straight from the pins
    assign dev_status = mdfs_status_t'({shutdown_n, thermal_warn_n});

    // Clears low in every state but running, covering power-up and -down
    assign phase_clear_n = (state == MDFS_RUN) ? 3'h7 : 3'h0;

    // Read mux; status shows the state and sticky flags
    wire logic [15:0] status_word = {9'h000, state, warn_seen, shut_seen};
    wire logic [15:0] sel_word =
        (addr == `MDFS_REG_CTRL)   ? {13'h0000, derate_en, clear_req, run} :
        (addr == `MDFS_REG_STATUS) ? status_word :
        (addr == `MDFS_REG_DUTY_A) ? duty[0] :
        (addr == `MDFS_REG_DUTY_B) ? duty[1] :
        (addr == `MDFS_REG_DUTY_C) ? duty[2] :
        (addr == `MDFS_REG_PERIOD) ? period : 16'h0000;

    // Next state logic
    always_comb begin
        next_state = state;
        unique case (state)
            MDFS_PWRUP:  next_state = run ? MDFS_CLR_LO : MDFS_PWRUP;
            MDFS_RUN: begin
                if (!run) begin
                    next_state = MDFS_IDLE;
                end else if (shut_now && run_prev) begin
                    // First running cycle ignored: the flag lags the clear edge
                    next_state = MDFS_WAIT;
                end
            end
            // A self-recovering fault ends before the wait; the clear is harmless then
            MDFS_WAIT:   next_state = (wait_done && clear_req) ? MDFS_CLR_LO : MDFS_WAIT;
            MDFS_CLR_LO: next_state = clr_done ? MDFS_RUN : MDFS_CLR_LO;
            MDFS_IDLE:   next_state = run ? MDFS_CLR_LO : MDFS_IDLE;
            default:     next_state = MDFS_PWRUP;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= MDFS_PWRUP;
        end else begin
            state <= next_state;
        end
    end

    // Running one cycle back; without it a stale flag re-enters the wait
    always_ff @(posedge clk) begin
        if (rst) begin
            run_prev <= 1'b0;
        end else begin
            run_prev <= drive_on;
        end
    end

    // Control register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            run       <= 1'b0;
            derate_en <= 1'b0;
        end else if (wr_ctrl) begin
            run       <= wdata[`MDFS_CTRL_RUN];
            derate_en <= wdata[`MDFS_CTRL_DERATE];
        end
    end

    // Clear request: set by software, dropped once used
    always_ff @(posedge clk) begin
        if (rst) begin
            clear_req <= 1'b0;
        end else if (wr_ctrl && wdata[`MDFS_CTRL_CLEAR]) begin
            clear_req <= 1'b1;
        end else if (state == MDFS_CLR_LO) begin
            clear_req <= 1'b0;
        end
    end

    // Duty and period registers, one write port per phase
    generate
        for (genvar i = 0; i < 3; i++) begin : g_duty
            always_ff @(posedge clk) begin
                if (rst) begin
                    duty[i] <= `MDFS_DUTY_RST;
                end else if (wr && (addr == `MDFS_REG_DUTY_A + 4'(i))) begin
                    duty[i] <= wdata;
                end
            end
            // Phase generator with low-side floor
            mdfs_pwm_phase u_phase (
                .clk    (clk),
                .rst    (rst),
                .enable (drive_on && !shut_now),
                .period (period),
                .duty   ((derate && derate_en) ? (duty[i] >> 1) : duty[i]),
                .count  (count),
                .pwm    (pwm[i])
            );
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            period <= `MDFS_PERIOD_RST;
        end else if (wr_period) begin
            period <= wdata;
        end
    end

    // Shared PWM counter
    always_ff @(posedge clk) begin
        if (rst || per_end) begin
            count <= 16'h0000;
        end else begin
            count <= count + 16'd1;
        end
    end

    // Time since shutdown; counts only while waiting, saturates
    always_ff @(posedge clk) begin
        if (rst || state != MDFS_WAIT) begin
            wait_cnt <= 32'h00000000;
        end else if (!wait_done) begin
            wait_cnt <= wait_cnt + 32'd1;
        end
    end

    // Clear-low pulse length
    always_ff @(posedge clk) begin
        if (rst || state != MDFS_CLR_LO) begin
            clr_cnt <= 3'h0;
        end else begin
            clr_cnt <= clr_cnt + 3'd1;
        end
    end

    // Sticky flags; a new event beats the read-clear
    always_ff @(posedge clk) begin
        if (rst) begin
            shut_seen <= 1'b0;
            warn_seen <= 1'b0;
            ok_prev   <= 1'b1;
        end else begin
            shut_seen <= (shut_now && ok_prev) || (shut_seen && !rd_status);
            warn_seen <= warn_now || (warn_seen && !rd_status);
            ok_prev   <= shutdown_n;
        end
    end

    // Warning derate level output
    always_ff @(posedge clk) begin
        if (rst) begin
            derate <= 1'b0;
        end else begin
            derate <= warn_now;
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rd ? sel_word : 16'h0000;
        end
    end

    // No clear edge until the full wait has passed
    a_clear_wait: assert property (@(posedge clk) disable iff (rst)
        (state == MDFS_WAIT && next_state == MDFS_CLR_LO) |-> wait_cnt >= REC_MAX - 32'd1)
        else $error("clear issued before the recovery wait");

    // All clears low together, then all released together
    a_clear_all: assert property (@(posedge clk) disable iff (rst)
        $rose(phase_clear_n[0]) |-> phase_clear_n == 3'h7 && $past(phase_clear_n) == 3'h0)
        else $error("clears not cycled on all three phases");

    // Clears low while powered up but not running
    a_pwrup_low: assert property (@(posedge clk) disable iff (rst)
        (state == MDFS_PWRUP) |-> phase_clear_n == 3'h0)
        else $error("clear released during power-up");

    // Drive stops one cycle after a shutdown flag
    a_fault_stop: assert property (@(posedge clk) disable iff (rst)
        shut_now |-> ##1 (pwm == 3'h0))
        else $error("pwm still driven after shutdown flag");

    // Derate follows the warning pin one cycle later
    a_derate: assert property (@(posedge clk) disable iff (rst)
        warn_now |=> derate)
        else $error("derate missed a thermal warning");
endmodule : mdfs_ctrl
`default_nettype wire

// *** tb/mdfs_dev_model.sv ***
// Purpose: behavioural model of the driver's protection and flag logic
// Assumes: detector indicators come from the bench on the one clock
// Notes:   flags are open-drain with pull-up, so a released line reads 1
`default_nettype none
module mdfs_dev_model (
    // Clock
    input  wire logic       clk,
    // Supplies and detectors from the bench
    input  wire logic       supply_ok,
    input  wire logic       warn_in,
    input  wire logic       hot_in,
    input  wire logic       uv_in,
    input  wire logic [2:0] oc_in,
    // Drive pins from the controller
    input  wire logic [2:0] pwm,
    input  wire logic [2:0] phase_clear_n,
    // Flags and output stage state
    output logic            shutdown_n,
    output logic            thermal_warn_n,
    output logic [2:0]      out_on,
    output logic [2:0]      weak_pull
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] HI_MAX = 6'h28; // Longest high-side run before a recharge gap
    logic       hot_latch;   // Latched thermal shutdown
    logic [2:0] oc_latch;    // Latched overcurrent shutdown per phase
    logic [5:0] hi_run [3];  // Unbroken high-side cycles per phase
    logic [2:0] recharge;    // Forced recharge gap per phase
    logic [2:0] seen_rise;   // Clear edges seen since latching
    logic [2:0] clr_q;       // Last clear levels
    logic       warn_s;      // Synchronised warning
    logic       uv_s;        // Synchronised undervoltage
    wire  [2:0] rise  = phase_clear_n & ~clr_q;
    wire        fault = hot_latch | uv_s | (|oc_latch) | ~supply_ok;
    // Power-on reset holds the logic defined whatever the supply order
    always_ff @(posedge clk) begin
        if (!supply_ok) begin
            hot_latch <= 1'b0;
            seen_rise <= 3'h0;
            clr_q     <= 3'h0;
            warn_s    <= 1'b0;
            uv_s      <= 1'b0;
            oc_latch  <= 3'h0;
            recharge  <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                hi_run[i] <= 6'h00;
            end
        end else begin
            // One clear edge on its own phase releases the overcurrent latch
            oc_latch <= oc_in | (oc_latch & ~rise);
            // Too long a high-side run forces a short recharge gap
            for (int i = 0; i < 3; i++) begin
                recharge[i] <= pwm[i] && (hi_run[i] == HI_MAX);
                hi_run[i]   <= (pwm[i] && hi_run[i] != HI_MAX) ? hi_run[i] + 6'h01 : 6'h00;
            end
            warn_s <= warn_in;
            uv_s   <= uv_in;
            clr_q  <= phase_clear_n;
            if (hot_in) begin
                hot_latch <= 1'b1;
                seen_rise <= 3'h0;
            end else if (hot_latch) begin
                // Only all three edges release the latch
                hot_latch <= ~&(seen_rise | rise);
                seen_rise <= seen_rise | rise;
            end
        end
    end
    // Open-drain flags, pulled up when released
    assign shutdown_n     = fault ? 1'b0 : 1'b1;
    assign thermal_warn_n = warn_s ? 1'b0 : 1'b1;
    // Stage off without supplies, on fault, or while its clear is low
    assign out_on    = fault ? 3'h0 : (pwm & phase_clear_n & ~recharge);
    assign weak_pull = supply_ok ? ~phase_clear_n : 3'h0;
endmodule : mdfs_dev_model
`default_nettype wire

// *** tb/mdfs_ctrl_bench.sv ***
// Purpose: self-checking bench for the fault supervisor controller
// Assumes: reads are checked one cycle after the strobe from a note queue
// Notes:   recovery wait shortened to 20 cycles to keep the run short
`include "mdfs_params.svh"
`default_nettype none
module mdfs_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import mdfs_pkg::*;
    localparam int RCYC = 20; // Shortened recovery wait
    logic clk = 0, rst = 1, wr = 0, rd = 0, rd_seen = 0;
    logic supply_ok = 0, warn_in = 0, hot_in = 0, uv_in = 0;
    logic [2:0] oc_in = 0;
    logic [3:0] addr = 0;
    logic [15:0] wdata = 0;
    wire [15:0] rdata;
    wire [2:0] pwm, phase_clear_n, out_on, weak_pull;
    wire shutdown_n, thermal_warn_n, derate;
    mdfs_status_t dev_status;
    int miscompares = 0, check_count = 0, cycles = 0;
    logic [31:0] note_q[$]; // Mask over expected read value
    always #50 clk = ~clk;
    mdfs_ctrl #(.RECOVER_CYC(RCYC)) uut (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pwm(pwm),
        .phase_clear_n(phase_clear_n), .shutdown_n(shutdown_n),
        .thermal_warn_n(thermal_warn_n), .dev_status(dev_status), .derate(derate));
    mdfs_dev_model dev (.clk(clk), .supply_ok(supply_ok), .warn_in(warn_in),
        .hot_in(hot_in), .uv_in(uv_in), .oc_in(oc_in), .pwm(pwm),
        .phase_clear_n(phase_clear_n),
        .shutdown_n(shutdown_n), .thermal_warn_n(thermal_warn_n), .out_on(out_on),
        .weak_pull(weak_pull));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run();
        if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a; wdata <= d; wr <= 1'b1; rd <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        addr <= a; rd <= 1'b1; wr <= 1'b0;
        note_q.push_back({m, e});
        @(posedge clk);
    endtask : rd_reg
    // High cycles of one phase over one full 20-cycle period
    task automatic count_pwm(input int p, input logic [15:0] exp);
        logic [15:0] hi;
        hi = 16'h0000;
        repeat (20) begin
            @(posedge clk);
            hi += 16'(pwm[p]);
        end
        check(hi, exp);
    endtask : count_pwm
    task automatic idle(input int n);
        wr <= 1'b0; rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle
    // Read data compared the cycle after each strobe; hang guard
    always @(posedge clk) begin
        logic [31:0] note;
        cycles++;
        if (rd_seen) begin
            note = note_q.pop_front();
            check(rdata & note[31:16], note[15:0]);
        end
        rd_seen <= rd;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        logic [15:0] duty[3];
        void'($urandom(32'hD002));
        repeat (4) @(posedge clk);
        check({13'h0, out_on}, 16'h0);
        repeat (4) @(posedge clk);
        supply_ok <= 1'b1;
        repeat (8) @(posedge clk);
        check({13'h0, weak_pull}, 16'h7);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(`MDFS_REG_CTRL, 16'h0, 16'hFFFF);
        rd_reg(`MDFS_REG_STATUS, 16'h0004, 16'hFFFF);
        rd_reg(`MDFS_REG_PERIOD, `MDFS_PERIOD_RST, 16'hFFFF);
        wr_reg(4'hF, 16'h1234);
        rd_reg(4'hF, 16'h0, 16'hFFFF);
        wr_reg(`MDFS_REG_PERIOD, 16'h0014);
        duty[0] = 16'h0020; // Above the period: clamped to keep a low part
        for (int i = 0; i < 3; i++) begin
            if (i > 0) duty[i] = 16'($urandom_range(19, 1));
            wr_reg(4'(`MDFS_REG_DUTY_A + i), duty[i]);
            rd_reg(4'(`MDFS_REG_DUTY_A + i), duty[i], 16'hFFFF);
        end
        wr_reg(`MDFS_REG_CTRL, 16'h0001);
        idle(30);
        check({13'h0, phase_clear_n}, 16'h7);
        for (int p = 0; p < 3; p++) begin
            count_pwm(p, p == 0 ? 16'd19 : duty[p]);
        end
        warn_in <= 1'b1;
        idle(4);
        check({14'h0, dev_status}, {14'h0, MDFS_ST_WARN});
        check({15'h0, derate}, 16'h1);
        wr_reg(`MDFS_REG_CTRL, 16'h0005);
        idle(2);
        count_pwm(1, duty[1] >> 1);
        hot_in <= 1'b1;
        idle(1);
        hot_in <= 1'b0;
        idle(3);
        check({14'h0, dev_status}, {14'h0, MDFS_ST_BOTH});
        check({13'h0, pwm | out_on}, 16'h0);
        warn_in <= 1'b0;
        idle(4);
        check({14'h0, dev_status}, {14'h0, MDFS_ST_SHUT});
        rd_reg(`MDFS_REG_STATUS, 16'h0013, 16'h007F);
        wr_reg(`MDFS_REG_CTRL, 16'h0003);
        idle(RCYC - 12);
        check({13'h0, phase_clear_n}, 16'h0);
        idle(RCYC + 10);
        check({12'h0, shutdown_n, phase_clear_n}, 16'hF);
        rd_reg(`MDFS_REG_STATUS, 16'h0008, 16'h007C);
        uv_in <= 1'b1;
        idle(4);
        check({14'h0, dev_status}, {14'h0, MDFS_ST_SHUT});
        uv_in <= 1'b0;
        idle(4);
        check({12'h0, shutdown_n, phase_clear_n}, 16'h8);
        wr_reg(`MDFS_REG_CTRL, 16'h0003);
        idle(RCYC + 10);
        check({13'h0, phase_clear_n}, 16'h7);
        oc_in <= 3'h2;
        idle(1);
        oc_in <= 3'h0;
        idle(3);
        check({14'h0, dev_status}, {14'h0, MDFS_ST_SHUT});
        wr_reg(`MDFS_REG_CTRL, 16'h0003);
        idle(RCYC + 10);
        check({12'h0, shutdown_n, phase_clear_n}, 16'hF);
        wr_reg(`MDFS_REG_CTRL, 16'h0000);
        idle(4);
        check({10'h0, phase_clear_n, out_on}, 16'h0);
        rd_reg(`MDFS_REG_STATUS, 16'h0040, 16'h007C);
        idle(3);
        complete_run();
    end
endmodule : mdfs_ctrl_bench
`default_nettype wire
